// ===== bench/tb_fault_interrupt_masking.sv
`timescale 1ns/1ns

// ****************************************
// Bench signals
// ****************************************
module tb_fault_interrupt_masking;
  logic               sys_clk = 0;
  logic               sys_rst = 1;
  logic               sys_ce = 1;
  fim_pkg::fim_req_s  reg_req = '0;
  fim_pkg::fim_live_s live_evt = '0;
  logic               cor = 0;
  logic               strap = 0;
  logic [1:0]         mode = 2'h0;
  logic [7:0]         reg_rdata;
  logic               int_req;
  logic [7:0]         rd_q[$];
  logic               int_q[$];
  logic               rd_seen = 0;
  int                 mismatches = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  integer             seed = 32'hcf70;
  logic [7:0]         v;

  fim_top uut (
    .sys_clk             (sys_clk),
    .sys_rst             (sys_rst),
    .sys_ce              (sys_ce),
    .reg_req             (reg_req),
    .live_evt            (live_evt),
    .clear_on_read_policy(cor),
    .event_mode          (mode),
    .six_channel_strap   (strap),
    .reg_rdata           (reg_rdata),
    .int_req             (int_req)
  );

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Checking side
  // ****************************************
  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t read exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_int(input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t int exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Outputs read here at the edge still hold what the previous edge settled
  always @(posedge sys_clk) begin
    if (rd_seen)
      cmp_rd(rd_q.pop_front(), reg_rdata);
    if (int_q.size() > 0)
      cmp_int(int_q.pop_front(), int_req);
    rd_seen <= reg_req.rd && sys_ce && !sys_rst;
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      conclude();
    end
  end

  // ****************************************
  // Driving side, all changes at the falling edge
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req.wr = 1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge sys_clk);
    reg_req.wr = 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_req.rd = 1;
    reg_req.addr = a;
    rd_q.push_back(e);
    @(negedge sys_clk);
    reg_req.rd = 0;
  endtask

  // Three cycles cover the two-edge latch path with margin
  task automatic ck(input logic e);
    repeat (3) @(negedge sys_clk);
    int_q.push_back(e);
  endtask

  task automatic do_reset(input logic s);
    @(negedge sys_clk);
    sys_rst = 1;
    strap = s;
    repeat (10) @(negedge sys_clk);
    sys_rst = 0;
  endtask

  initial begin
    do_reset(0);
    rd(8'h29, 8'hFF);
    rd(8'h2A, 8'h03);
    rd(8'h2B, 8'h00);
    rd(8'h2C, 8'h00);
    rd(8'h30, 8'h00);
    ck(0);
    $display("test reset_values done");
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      wr(8'(8'h29 + i), v);
      rd(8'(8'h29 + i), v);
    end
    wr(8'h2C, 8'hA5);
    rd(8'h2C, 8'h00);
    sys_ce = 0;
    wr(8'h2B, ~v);
    sys_ce = 1;
    rd(8'h2B, v);
    wr(8'h29, 8'hFF);
    wr(8'h2A, 8'h03);
    wr(8'h2B, 8'h00);
    $display("test readback done");
    for (int b = 0; b < 4; b++) begin
      v = 8'h10 << b;
      live_evt.sys = 4'(1 << b);
      wr(8'h29, v);
      ck(0);
      wr(8'h29, ~v);
      ck(1);
      rd(8'h2C, v);
      live_evt.sys = 4'h0;
      rd(8'h2C, v);
      rd(8'h2C, 8'h00);
      ck(0);
    end
    $display("test system_events done");
    cor = 1;
    wr(8'h29, 8'h7F);
    live_evt.sys = 4'h8;
    ck(1);
    rd(8'h2C, 8'h80);
    rd(8'h2C, 8'h00);
    ck(0);
    live_evt.sys = 4'h0;
    @(negedge sys_clk);
    live_evt.sys = 4'h8;
    rd(8'h2C, 8'h80);
    live_evt.sys = 4'h0;
    cor = 0;
    wr(8'h29, 8'hFF);
    $display("test clear_policy done");
    live_evt.chan = 6'h20;
    for (int t = 0; t < 8; t++) begin
      live_evt.ftype = 8'h01 << t;
      wr(8'h2B, ~(8'h01 << t));
      ck(1);
      wr(8'h2B, 8'h01 << t);
      ck(0);
    end
    $display("test fault_types done");
    // The strap is only taken after reset, so each variant needs its own reset
    live_evt.ftype = 8'h01;
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0]);
      for (int c = 0; c < 6; c++) begin
        live_evt.chan = 6'(1 << c);
        v = 8'h04 << c;
        wr(8'h2A, v | 8'h03);
        ck(0);
        wr(8'h2A, ~v);
        ck(c > 1 || s == 1);
      end
    end
    $display("test channels done");
    live_evt.chan = 6'h00;
    live_evt.vbat = 1;
    ck(0);
    wr(8'h2A, 8'h02);
    ck(0);
    // Pulse modes are not built and must behave as the level mode
    mode = 2'($random(seed)) | 2'h2;
    wr(8'h2A, 8'hFD);
    ck(1);
    live_evt.ftype = 8'h00;
    ck(0);
    $display("test battery_short done");
    conclude();
  end
endmodule

// ===== include/fim_pkg.sv
package fim_pkg;

  // ****************************************
  // Register map (page 0)
  // ****************************************
  localparam logic [7:0] SYS_MASK_ADDR  = 8'h29;
  localparam logic [7:0] CHAN_MASK_ADDR = 8'h2A;
  localparam logic [7:0] TYPE_MASK_ADDR = 8'h2B;
  localparam logic [7:0] SYS_LATCH_ADDR = 8'h2C;

  localparam logic [7:0] SYS_MASK_RESET  = 8'hFF;
  localparam logic [7:0] CHAN_MASK_RESET = 8'h03;
  localparam logic [7:0] TYPE_MASK_RESET = 8'h00;
  localparam logic [7:0] READ_RESET      = 8'h00;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int SYS_EVT_W   = 4;
  localparam int SYS_EVT_LSB = 4;
  localparam int SYS_EVT_MSB = 7;
  localparam int CHAN_W      = 6;
  localparam int CHAN_LSB    = 2;
  localparam int CHAN_MSB    = 7;
  localparam int VBAT_BIT    = 1;
  localparam int TYPE_W      = 8;
  localparam int CH56_LSB    = 2;
  localparam int CH56_MSB    = 3;

  localparam logic [1:0] CH56_FORCED_MASK = 2'h3;
  localparam logic [1:0] EVENT_MODE_LEVEL = 2'h0;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [SYS_EVT_W-1:0] sys;   // clk err, pll lock, over temp, over current
    logic [CHAN_W-1:0]    chan;  // channel 1 in msb
    logic                 vbat;  // short to battery while battery below bias
    logic [TYPE_W-1:0]    ftype; // open, pair short, gnd p/n, bias p/n, batt p/n
  } fim_live_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fim_req_s;

endpackage

// ===== src/fim_latch.sv
`timescale 1ns/1ns

// ****************************************
// Sticky event latch with clear on read
// ****************************************
module fim_latch #(
  parameter int WIDTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             sys_ce,
  input  wire logic [WIDTH-1:0] live,
  input  wire logic             rd_clr,
  input  wire logic             cor_policy,
  output logic      [WIDTH-1:0] latched
);

  logic [WIDTH-1:0] live_reg;
  logic [WIDTH-1:0] set_v;
  logic [WIDTH-1:0] clr_v;
  logic [WIDTH-1:0] latched_next;

  always_comb begin
    // Policy 1 only re-arms on a fresh rising edge of the live status
    set_v = cor_policy ? (live & ~live_reg) : live; // see R18
    // Policy 0 keeps the bit while the condition still holds
    clr_v = rd_clr ? (cor_policy ? {WIDTH{1'b1}} : ~live) : '0; // see R18
    // A set in the clearing cycle is never lost
    latched_next = set_v | (latched & ~clr_v); // see R17
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      live_reg <= '0;
      latched  <= '0;
    end else if (sys_ce) begin
      live_reg <= live;
      latched  <= latched_next;
    end
  end

endmodule

// ===== src/fim_top.sv
`timescale 1ns/1ns

// How it works
// R1: System mask bit 7 gates serial clock error interrupt; resets masked.
// R2: System mask bit 6 gates PLL lock interrupt; resets masked.
// R3: System mask bit 5 gates bias/boost over-temperature interrupt; resets masked.
// R4: System mask bit 4 gates bias/boost over-current interrupt; resets masked.
// R5: Channel mask at 0x2A resets 03; bits 7..2 mask channels 1..6.
// R6: Per-channel fault mask bits reset to zero, unmasked.
// R7: Channel 5 and 6 masks matter only on the six-channel variant.
// R8: Channel mask bit 1 gates battery short below bias; resets masked.
// R9: Fault type mask at 0x2B resets to zero, all unmasked.
// R10: Fault type bit 7 masks open input interrupt.
// R11: Fault type bit 6 masks pair short interrupt.
// R12: Fault type bits 5,4 mask positive/negative short to ground.
// R13: Fault type bits 3,2 mask positive/negative short to bias.
// R14: Fault type bits 1,0 mask positive/negative short to battery.
// R15: Read-only system latch at 0x2C, resets zero, bits 3..0 read zero.
// R16: Interrupt asserts whenever any unmasked latched event is present.
// R17: Latch bits 7..4 record system events and clear on read.
// R18: Policy 0 clears only if live low; policy 1 clears, re-sets on rise.
// R19: Reserved mask bits store writes but never affect interrupts.
module fim_top (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               sys_ce,
  input  wire fim_pkg::fim_req_s  reg_req,
  input  wire fim_pkg::fim_live_s live_evt,
  input  wire logic               clear_on_read_policy,
  input  wire logic [1:0]         event_mode,
  input  wire logic               six_channel_strap,
  output logic      [7:0]         reg_rdata,
  output logic                    int_req
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]                    system_event_mask_reg;
  logic [7:0]                    channel_fault_mask_reg;
  logic [7:0]                    fault_type_mask_reg;
  logic                          six_channel_reg;
  logic                          strap_taken_reg;
  logic                          strap_meta_reg;
  logic                          strap_sync_reg;
  logic [1:0]                    strap_arm_reg;
  logic [fim_pkg::SYS_EVT_W-1:0] sys_latched;
  logic [fim_pkg::SYS_EVT_W-1:0] sys_mask_bits;
  logic [7:0]                    system_event_latch;
  logic [7:0]                    rdata_next;
  logic [fim_pkg::CHAN_W-1:0]    chan_mask_eff;
  logic                          sys_cause;
  logic                          chan_cause;
  logic                          vbat_cause;
  logic                          type_cause;
  logic                          int_next;
  logic                          latch_rd;

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      system_event_mask_reg <= fim_pkg::SYS_MASK_RESET; // see R1
    end else if (sys_ce && reg_req.wr && reg_req.addr == fim_pkg::SYS_MASK_ADDR) begin
      system_event_mask_reg <= reg_req.wdata; // see R19
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_fault_mask_reg <= fim_pkg::CHAN_MASK_RESET; // see R5
    end else if (sys_ce && reg_req.wr && reg_req.addr == fim_pkg::CHAN_MASK_ADDR) begin
      channel_fault_mask_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_type_mask_reg <= fim_pkg::TYPE_MASK_RESET; // see R9
    end else if (sys_ce && reg_req.wr && reg_req.addr == fim_pkg::TYPE_MASK_ADDR) begin
      fault_type_mask_reg <= reg_req.wdata;
    end
  end

  // ****************************************
  // Variant strap
  // ****************************************
  // The strap is a board pin with no relation to sys_clk, so it is synchronised first
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
      strap_arm_reg  <= 2'h0;
    end else if (sys_ce) begin
      strap_meta_reg <= six_channel_strap;
      strap_sync_reg <= strap_meta_reg;
      strap_arm_reg  <= {strap_arm_reg[0], 1'b1};
    end
  end

  // Caught once the sync chain has filled, so a later strap glitch cannot unmask channels
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      six_channel_reg <= 1'b0;
      strap_taken_reg <= 1'b0;
    end else if (sys_ce && strap_arm_reg[1] && !strap_taken_reg) begin
      six_channel_reg <= strap_sync_reg; // see R7
      strap_taken_reg <= 1'b1;
    end
  end

  // ****************************************
  // System event latch
  // ****************************************
  assign latch_rd = reg_req.rd && reg_req.addr == fim_pkg::SYS_LATCH_ADDR;

  fim_latch #(
    .WIDTH (fim_pkg::SYS_EVT_W)
  ) u_sys_latch (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .sys_ce     (sys_ce),
    .live       (live_evt.sys),
    .rd_clr     (latch_rd),
    .cor_policy (clear_on_read_policy),
    .latched    (sys_latched)
  );

  // Low nibble is reserved and reads zero
  assign system_event_latch = {sys_latched, 4'h0}; // see R15

  // ****************************************
  // Readback
  // ****************************************
  always_comb begin
    case (reg_req.addr)
      fim_pkg::SYS_MASK_ADDR:  rdata_next = system_event_mask_reg;
      fim_pkg::CHAN_MASK_ADDR: rdata_next = channel_fault_mask_reg;
      fim_pkg::TYPE_MASK_ADDR: rdata_next = fault_type_mask_reg;
      fim_pkg::SYS_LATCH_ADDR: rdata_next = system_event_latch; // see R15
      default:                 rdata_next = fim_pkg::READ_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= fim_pkg::READ_RESET;
    end else if (sys_ce && reg_req.rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // ****************************************
  // Interrupt combine
  // ****************************************
  always_comb begin
    chan_mask_eff = channel_fault_mask_reg[fim_pkg::CHAN_MSB:fim_pkg::CHAN_LSB]; // see R5
    // Four-channel parts have no channel 5 or 6 to report
    if (!six_channel_reg) begin
      chan_mask_eff[fim_pkg::CH56_MSB-fim_pkg::CH56_LSB:0] = fim_pkg::CH56_FORCED_MASK; // see R7
    end
  end

  // Reserved mask bits 3..0 of the system mask are never looked at
  assign sys_mask_bits = system_event_mask_reg[fim_pkg::SYS_EVT_MSB:fim_pkg::SYS_EVT_LSB]; // see R19
  assign sys_cause     = |(sys_latched & ~sys_mask_bits); // see R1 R2 R3 R4
  assign chan_cause = |(live_evt.chan & ~chan_mask_eff); // see R6
  assign vbat_cause = live_evt.vbat & ~channel_fault_mask_reg[fim_pkg::VBAT_BIT]; // see R8
  // A channel fault interrupts only if its fault kind is also unmasked
  assign type_cause = |(live_evt.ftype & ~fault_type_mask_reg); // see R10 R11 R12 R13 R14

  always_comb begin
    // Only the level mode is built; the pulse modes fall back to level
    int_next = sys_cause | ((chan_cause | vbat_cause) & type_cause); // see R16
    if (event_mode != fim_pkg::EVENT_MODE_LEVEL) begin
      int_next = sys_cause | ((chan_cause | vbat_cause) & type_cause);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_req <= 1'b0;
    end else if (sys_ce) begin
      int_req <= int_next; // see R16
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  clk_err_int_a: assert property ( // see R1
    sys_ce && sys_latched[3] && !system_event_mask_reg[7] |=> int_req)
    else $error("unmasked clock error did not raise interrupt");

  pll_int_a: assert property ( // see R2
    sys_ce && sys_latched[2] && !system_event_mask_reg[6] |=> int_req)
    else $error("unmasked pll lock did not raise interrupt");

  quiet_no_int_a: assert property ( // see R16
    sys_ce && !sys_cause && !((chan_cause | vbat_cause) & type_cause) |=> !int_req)
    else $error("interrupt with no unmasked cause");

  over_cur_int_a: assert property ( // see R4
    sys_ce && sys_latched[0] && !system_event_mask_reg[4] |=> int_req)
    else $error("unmasked over current did not raise interrupt");

  chan_one_int_a: assert property ( // see R6
    sys_ce && live_evt.chan[5] && !channel_fault_mask_reg[7] && live_evt.ftype[7] &&
    !fault_type_mask_reg[7] |=> int_req)
    else $error("channel 1 open fault did not raise interrupt");

  ch56_gate_a: assert property ( // see R7
    !six_channel_reg |-> chan_mask_eff[1:0] == 2'b11)
    else $error("channel 5 or 6 active on four-channel variant");

  vbat_int_a: assert property ( // see R8
    sys_ce && live_evt.vbat && !channel_fault_mask_reg[1] && live_evt.ftype[0] &&
    !fault_type_mask_reg[0] |=> int_req)
    else $error("battery short did not raise interrupt");

  type_block_a: assert property ( // see R11
    sys_ce && !sys_cause && fault_type_mask_reg == 8'hFF |=> !int_req)
    else $error("fully masked fault types still interrupt");

  latch_read_a: assert property ( // see R15
    sys_ce && latch_rd |=> reg_rdata[3:0] == 4'h0 && reg_rdata[7:4] == $past(sys_latched))
    else $error("latch readback wrong");

  keep_live_a: assert property ( // see R18
    sys_ce && latch_rd && !clear_on_read_policy && live_evt.sys[3] |=> sys_latched[3])
    else $error("policy 0 cleared a bit with live status high");

  clear_read_a: assert property ( // see R17
    sys_ce && latch_rd && clear_on_read_policy && live_evt.sys == 4'h0 |=> sys_latched == 4'h0)
    else $error("policy 1 read did not clear latch");

  mask_store_a: assert property ( // see R19
    sys_ce && reg_req.wr && reg_req.addr == fim_pkg::SYS_MASK_ADDR
    |=> system_event_mask_reg == $past(reg_req.wdata))
    else $error("system mask write not stored");

  over_temp_int_a: assert property ( // see R3
    sys_ce && sys_latched[1] && !system_event_mask_reg[5] |=> int_req)
    else $error("unmasked over temperature did not raise interrupt");

  sys_masked_a: assert property ( // see R19
    sys_ce && system_event_mask_reg[7:4] == 4'hF && live_evt.chan == 6'h00 && !live_evt.vbat
    |=> !int_req)
    else $error("fully masked system events still interrupt");

  chan_masked_a: assert property ( // see R5
    sys_ce && !sys_cause && !live_evt.vbat && live_evt.chan == 6'h20 &&
    channel_fault_mask_reg[7] |=> !int_req)
    else $error("masked channel 1 fault still interrupts");

  vbat_masked_a: assert property ( // see R8
    sys_ce && !sys_cause && live_evt.chan == 6'h00 && channel_fault_mask_reg[1] |=> !int_req)
    else $error("masked battery short still interrupts");

  ch56_quiet_a: assert property ( // see R7
    sys_ce && !six_channel_reg && !sys_cause && !live_evt.vbat &&
    live_evt.chan[5:2] == 4'h0 |=> !int_req)
    else $error("channel 5 or 6 fault interrupts on four-channel variant");

  strap_hold_a: assert property ( // see R7
    strap_taken_reg |=> $stable(six_channel_reg))
    else $error("variant strap changed after it was taken");

  rdata_hold_a: assert property ( // see R15
    !(sys_ce && reg_req.rd) |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  open_mask_a: assert property ( // see R10
    sys_ce && !sys_cause && live_evt.ftype == 8'h80 && fault_type_mask_reg[7] |=> !int_req)
    else $error("masked open input still interrupts");

  pair_mask_a: assert property ( // see R11
    sys_ce && !sys_cause && live_evt.ftype == 8'h40 && fault_type_mask_reg[6] |=> !int_req)
    else $error("masked pair short still interrupts");

  gnd_mask_a: assert property ( // see R12
    sys_ce && !sys_cause && (live_evt.ftype & 8'hCF) == 8'h00 &&
    fault_type_mask_reg[5:4] == 2'h3 |=> !int_req)
    else $error("masked ground short still interrupts");

  bias_mask_a: assert property ( // see R13
    sys_ce && !sys_cause && (live_evt.ftype & 8'hF3) == 8'h00 &&
    fault_type_mask_reg[3:2] == 2'h3 |=> !int_req)
    else $error("masked bias short still interrupts");

  batt_mask_a: assert property ( // see R14
    sys_ce && !sys_cause && (live_evt.ftype & 8'hFC) == 8'h00 &&
    fault_type_mask_reg[1:0] == 2'h3 |=> !int_req)
    else $error("masked battery sense short still interrupts");

  rearm_hold_a: assert property ( // see R18
    sys_ce && latch_rd && clear_on_read_policy && live_evt.sys[3] && $past(live_evt.sys[3]) &&
    $past(sys_ce) && !$past(sys_rst) |=> !sys_latched[3])
    else $error("policy 1 latch set again without a new rise");

  int_rise_c: cover property (!int_req ##1 int_req);
  vbat_int_c: cover property (sys_ce && vbat_cause && type_cause ##1 int_req);
  ce_freeze_c: cover property (!sys_ce && reg_req.wr);
  latch_clr_c: cover property (sys_latched != 4'h0 ##1 latch_rd ##1 sys_latched == 4'h0);
  chan_int_c: cover property (sys_ce && chan_cause && type_cause ##1 int_req);

endmodule
